/* inc/skip_pkg.sv */
// constants shared by the skip instruction decoder and its top
// Function
// - standby test 0000000111 skips when return flag set
// - serial test 1010001001 skips when request set
// - taken serial skip clears the serial request
// - serial select high makes serial test a nop
// - serial select is bit 3 of control two
// - timer one test skips when its request set
// - taken timer one skip clears its request
// - timer one select high makes test a nop
// - timer one select is bit 2 of control one
package skip_pkg;
    // instruction encodings
    localparam logic [9:0] OP_STANDBY = 10'h007;
    localparam logic [9:0] OP_SERIAL = 10'h289;
    localparam logic [9:0] OP_TIMER_ONE = 10'h280;
    // select bit positions
    localparam int SERIAL_SEL_BIT = 3;
    localparam int TIMER_SEL_BIT = 2;
    // register byte offsets
    localparam logic [7:0] ADR_CTRL_ONE = 8'h00;
    localparam logic [7:0] ADR_CTRL_TWO = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_MASK = 8'h0c;
    localparam logic [7:0] ADR_FLAGS = 8'h10;
    // status and flags register layout
    localparam int ST_SERIAL = 0;
    localparam int ST_TIMER = 1;
    localparam int ST_SKIP = 2;
    localparam int FL_STANDBY = 2;
    // values after reset
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [2:0] STATUS_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
endpackage

/* inc/skip_decode_if.sv */
// signals between the core top and the skip decoder
`timescale 1ns/1ns
interface skip_decode_if;
    logic [9:0] word;
    logic exec;
    logic standby_flag;
    logic serial_flag;
    logic timer_flag;
    logic serial_sel;
    logic timer_sel;
    logic skip;
    logic clear_serial;
    logic clear_timer;
    modport decoder (
        input word, exec, standby_flag, serial_flag, timer_flag, serial_sel, timer_sel,
        output skip, clear_serial, clear_timer
    );
    modport core (
        output word, exec, standby_flag, serial_flag, timer_flag, serial_sel, timer_sel,
        input skip, clear_serial, clear_timer
    );
endinterface

/* src/skip_decoder.sv */
// decode of the three flag skip test instructions
`timescale 1ns/1ns
module skip_decoder (
    skip_decode_if.decoder d
);
    logic hit_standby;
    logic hit_serial;
    logic hit_timer;
    logic take_serial;
    logic take_timer;

    always_comb begin
        hit_standby = d.exec && (d.word == skip_pkg::OP_STANDBY);
        hit_serial = d.exec && (d.word == skip_pkg::OP_SERIAL);
        hit_timer = d.exec && (d.word == skip_pkg::OP_TIMER_ONE);
        // select high turns the test into a nop
        take_serial = hit_serial && !d.serial_sel && d.serial_flag;
        take_timer = hit_timer && !d.timer_sel && d.timer_flag;
        d.skip = (hit_standby && d.standby_flag) || take_serial || take_timer;
        d.clear_serial = take_serial;
        d.clear_timer = take_timer;
    end
endmodule

/* src/flag_skip_test_instructions.sv */
// flag skip test instructions with wishbone control and interrupt
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
module flag_skip_test_instructions (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // core instruction stream
    input wire logic [9:0] instr_i,
    input wire logic instr_valid_i,
    output logic skip_o,
    // flag sources
    input wire logic standby_return_i,
    input wire logic serial_event_i,
    input wire logic timer_one_event_i,
    output logic serial_request_flag_o,
    output logic timer_one_request_flag_o,
    // interrupt
    output logic irq_o,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    logic [3:0] irq_control_one;
    logic [3:0] irq_control_two;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic serial_request_flag;
    logic timer_one_request_flag;
    logic skip;
    logic wb_req;
    logic wb_wr;
    logic wb_rd;
    logic [31:0] next_rdata;
    logic [2:0] status_set;
    logic [2:0] status_clr;

    skip_decode_if dec ();

    // drive the decoder; a skipped slot never executes
    assign dec.word = instr_i;
    assign dec.exec = instr_valid_i && !skip;
    assign dec.standby_flag = standby_return_i;
    assign dec.serial_flag = serial_request_flag;
    assign dec.timer_flag = timer_one_request_flag;
    assign dec.serial_sel = irq_control_two[skip_pkg::SERIAL_SEL_BIT];
    assign dec.timer_sel = irq_control_one[skip_pkg::TIMER_SEL_BIT];

    skip_decoder u_decoder (
        .d(dec)
    );

    // bus strobes
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
    assign wb_rd = wb_req && !wb_we_i;

    // skip of the next slot
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            skip <= 1'b0;
        end else if (ce_i) begin
            skip <= dec.skip;
        end
    end

    // serial request flag, a new request wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_request_flag <= 1'b0;
        end else if (ce_i) begin
            if (serial_event_i) begin
                serial_request_flag <= 1'b1;
            end else if (dec.clear_serial) begin
                serial_request_flag <= 1'b0;
            end
        end
    end

    // timer one request flag, a new request wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_one_request_flag <= 1'b0;
        end else if (ce_i) begin
            if (timer_one_event_i) begin
                timer_one_request_flag <= 1'b1;
            end else if (dec.clear_timer) begin
                timer_one_request_flag <= 1'b0;
            end
        end
    end

    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_control_one <= skip_pkg::CTRL_RST;
            irq_control_two <= skip_pkg::CTRL_RST;
        end else if (ce_i && wb_wr) begin
            if (wb_adr_i == skip_pkg::ADR_CTRL_ONE) begin
                irq_control_one <= wb_dat_i[3:0];
            end
            if (wb_adr_i == skip_pkg::ADR_CTRL_TWO) begin
                irq_control_two <= wb_dat_i[3:0];
            end
        end
    end

    // sticky status events and write-one-to-clear
    always_comb begin
        status_set = 3'h0;
        status_set[skip_pkg::ST_SERIAL] = serial_event_i;
        status_set[skip_pkg::ST_TIMER] = timer_one_event_i;
        status_set[skip_pkg::ST_SKIP] = dec.skip;
        status_clr = 3'h0;
        if (wb_wr && wb_adr_i == skip_pkg::ADR_STATUS) begin
            status_clr = wb_dat_i[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= skip_pkg::STATUS_RST;
        end else if (ce_i) begin
            irq_status <= (irq_status & ~status_clr) | status_set;
        end
    end

    // interrupt mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= skip_pkg::MASK_RST;
        end else if (ce_i && wb_wr && wb_adr_i == skip_pkg::ADR_MASK) begin
            irq_mask <= wb_dat_i[2:0];
        end
    end

    // interrupt output, one cycle behind status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // read mux, unmapped reads give zero
    always_comb begin
        next_rdata = 32'h0;
        case (wb_adr_i)
            skip_pkg::ADR_CTRL_ONE: begin
                next_rdata[3:0] = irq_control_one;
            end
            skip_pkg::ADR_CTRL_TWO: begin
                next_rdata[3:0] = irq_control_two;
            end
            skip_pkg::ADR_STATUS: begin
                next_rdata[2:0] = irq_status;
            end
            skip_pkg::ADR_MASK: begin
                next_rdata[2:0] = irq_mask;
            end
            skip_pkg::ADR_FLAGS: begin
                next_rdata[skip_pkg::ST_SERIAL] = serial_request_flag;
                next_rdata[skip_pkg::ST_TIMER] = timer_one_request_flag;
                next_rdata[skip_pkg::FL_STANDBY] = standby_return_i;
            end
            default: begin
                next_rdata = 32'h0;
            end
        endcase
    end

    // bus answer, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            if (wb_rd) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

    // output copies
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            skip_o <= 1'b0;
            serial_request_flag_o <= 1'b0;
            timer_one_request_flag_o <= 1'b0;
        end else if (ce_i) begin
            skip_o <= dec.skip;
            serial_request_flag_o <= serial_request_flag;
            timer_one_request_flag_o <= timer_one_request_flag;
        end
    end

    // standby test skips when the return flag is set
    standby_skip_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && instr_valid_i && !skip && instr_i == skip_pkg::OP_STANDBY
            && standby_return_i |=> skip_o
    ) else $error("standby test did not skip");

    // standby test with flag low does not skip and alters nothing
    standby_plain_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && instr_valid_i && !skip && instr_i == skip_pkg::OP_STANDBY
            && !standby_return_i |=> !skip_o
            && serial_request_flag == $past(serial_request_flag | serial_event_i)
            && timer_one_request_flag == $past(timer_one_request_flag | timer_one_event_i)
    ) else $error("standby test misbehaved with flag low");

    // serial test skips and clears its request
    serial_take_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && instr_valid_i && !skip && instr_i == skip_pkg::OP_SERIAL
            && !irq_control_two[3] && serial_request_flag && !serial_event_i
            |=> skip_o && !serial_request_flag ##1 (!serial_request_flag_o || !$past(ce_i))
    ) else $error("serial test skip or clear missing");

    // a taken serial skip with no new serial event leaves the flag low next cycle
    serial_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && dec.clear_serial && !serial_event_i |=> !serial_request_flag
    ) else $error("serial request not cleared");

    // serial select high acts as a nop
    serial_nop_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && instr_valid_i && instr_i == skip_pkg::OP_SERIAL && irq_control_two[3]
            |=> !skip_o && (serial_request_flag || !$past(serial_request_flag))
    ) else $error("serial test not a nop with select high");

    // serial select comes from control two bit 3
    serial_sel_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wb_wr && wb_adr_i == skip_pkg::ADR_CTRL_TWO
            |=> dec.serial_sel == $past(wb_dat_i[3])
    ) else $error("serial select taken from wrong bit");

    // timer one test skips when its request is set
    timer_take_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && instr_valid_i && !skip && instr_i == skip_pkg::OP_TIMER_ONE
            && !irq_control_one[2] && timer_one_request_flag |=> skip_o
    ) else $error("timer one test did not skip");

    // taken timer skip clears the request unless a new one arrives
    timer_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && dec.clear_timer |=> timer_one_request_flag == $past(timer_one_event_i)
    ) else $error("timer one request not cleared");

    // timer select high acts as a nop
    timer_nop_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && instr_valid_i && instr_i == skip_pkg::OP_TIMER_ONE && irq_control_one[2]
            |=> !skip_o && (timer_one_request_flag || !$past(timer_one_request_flag))
    ) else $error("timer one test not a nop with select high");

    // writing control one bit 2 governs the timer test
    timer_sel_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wb_wr && wb_adr_i == skip_pkg::ADR_CTRL_ONE
            |=> dec.timer_sel == $past(wb_dat_i[2])
    ) else $error("timer one select not from control one bit 2");

    // a skipped slot is never itself a skip source
    skip_chain_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && skip_o |=> !skip_o || !$past(ce_i)
    ) else $error("skip asserted twice in a row");

    // ack lasts one cycle
    ack_pulse_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wb_ack_o |=> !wb_ack_o
    ) else $error("ack held more than one cycle");

    // interrupt follows masked status
    irq_follow_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i |=> irq_o == |$past(irq_status & irq_mask)
    ) else $error("interrupt does not follow masked status");

    // enable low freezes outputs
    enable_freeze_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(skip_o) && $stable(wb_ack_o) && $stable(irq_o)
    ) else $error("state moved with enable low");

    // every taken request is answered in the next cycle
    ack_answer_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wb_req |=> wb_ack_o
    ) else $error("request not answered in one cycle");

    // flag outputs copy the internal flags one cycle late
    flag_copy_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i |=> serial_request_flag_o == $past(serial_request_flag)
            && timer_one_request_flag_o == $past(timer_one_request_flag)
    ) else $error("flag outputs do not follow internal flags");

    // a taken skip marks the skip status bit
    skip_status_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && dec.skip |=> irq_status[skip_pkg::ST_SKIP]
    ) else $error("skip status bit not set");

    // a serial event always sets its request
    serial_event_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && serial_event_i |=> serial_request_flag
    ) else $error("serial event lost");

    // a timer one event always sets its request
    timer_event_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && timer_one_event_i |=> timer_one_request_flag
    ) else $error("timer one event lost");

    // control one reads back what it holds
    read_ctrl_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wb_rd && wb_adr_i == skip_pkg::ADR_CTRL_ONE
            |=> wb_dat_o == {28'h0000000, $past(irq_control_one)}
    ) else $error("control one read data wrong");

    // writing ones clears status bits with no new event
    status_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wb_wr && wb_adr_i == skip_pkg::ADR_STATUS
            |=> (irq_status & $past(wb_dat_i[2:0] & ~status_set)) == 3'h0
    ) else $error("status bits not cleared by ones");
endmodule

/* tb/tb_top.sv */
// self-checking bench for the flag skip test instructions
`timescale 1ns/1ns
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [9:0] instr_i = 10'h000;
    logic instr_valid_i = 1'b0;
    logic standby_return_i = 1'b0;
    logic [1:0] ev = 2'h0;
    logic ce = 1'b1;
    logic [3:0] sel = 4'hf;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic skip_o;
    logic irq_o;
    logic ack;
    logic [1:0] flag_o;
    logic [31:0] rdat;
    logic [31:0] lfsr = 32'he026;
    int errors = 0;
    int n_compared = 0;

    always #5 clk_i = ~clk_i;

    flag_skip_test_instructions u_flag_skip_test_instructions (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce),
        .instr_i(instr_i),
        .instr_valid_i(instr_valid_i),
        .skip_o(skip_o),
        .standby_return_i(standby_return_i),
        .serial_event_i(ev[0]),
        .timer_one_event_i(ev[1]),
        .serial_request_flag_o(flag_o[0]),
        .timer_one_request_flag_o(flag_o[1]),
        .irq_o(irq_o),
        .wb_cyc_i(cyc),
        .wb_stb_i(cyc),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i(wdat),
        .wb_dat_o(rdat),
        .wb_ack_o(ack)
    );

    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic exp_skip(input logic flag, input logic sel);
        return flag & ~sel;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one classic cycle: hold until ack is sampled at an edge, release at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            errors++;
            complete_run;
        end
        q = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic run_op(input logic [9:0] op, output logic sk);
        @(posedge clk_i);
        instr_i <= op;
        instr_valid_i <= 1'b1;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        #1;
        sk = skip_o;
        @(posedge clk_i);
        #1;
    endtask

    task automatic pulse(input int idx);
        @(posedge clk_i);
        ev[idx] <= 1'b1;
        @(posedge clk_i);
        ev[idx] <= 1'b0;
    endtask

    initial begin
        logic sk;
        logic esk;
        logic mflag;
        logic s;
        logic [9:0] op;
        logic [31:0] q;
        int sb;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        // registers and one unmapped place read zero after reset
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, 8'(i * 4), 32'h00000000, q);
            check(q, 32'h00000000, "reset value");
        end
        // standby test with the return flag low then high
        for (int v = 0; v < 2; v++) begin
            @(posedge clk_i);
            standby_return_i <= v[0];
            run_op(skip_pkg::OP_STANDBY, sk);
            check(32'(sk), 32'(exp_skip(v[0], 1'b0)), "standby skip");
            wb(1'b0, skip_pkg::ADR_FLAGS, 32'h00000000, q);
            check(32'(q[skip_pkg::FL_STANDBY]), 32'(v[0]), "standby flag");
        end
        // serial then timer one: idle, select set with flag, select clear with flag
        for (int u = 0; u < 2; u++) begin
            mflag = 1'b0;
            sb = (u == 1) ? skip_pkg::TIMER_SEL_BIT : skip_pkg::SERIAL_SEL_BIT;
            for (int c = 0; c < 3; c++) begin
                s = (c == 1);
                wb(1'b1, (u == 1) ? skip_pkg::ADR_CTRL_ONE : skip_pkg::ADR_CTRL_TWO,
                   32'(s ? (4'h1 << sb) : (4'hf ^ (4'h1 << sb))), q);
                if (c == 1) begin
                    pulse(u);
                    mflag = 1'b1;
                end
                run_op((u == 1) ? skip_pkg::OP_TIMER_ONE : skip_pkg::OP_SERIAL, sk);
                esk = exp_skip(mflag, s);
                if (esk) begin
                    mflag = 1'b0;
                end
                check(32'(sk), 32'(esk), "request skip");
                check(32'(flag_o[u]), 32'(mflag), "request flag");
            end
        end
        // a write with sel bit 0 low is acked and ignored
        @(posedge clk_i);
        sel <= 4'he;
        wb(1'b1, skip_pkg::ADR_CTRL_ONE, 32'h0000000f, q);
        sel <= 4'hf;
        wb(1'b0, skip_pkg::ADR_CTRL_ONE, 32'h00000000, q);
        check(q, 32'h0000000b, "sel low write ignored");
        // random other words with both flags pending never skip
        pulse(0);
        pulse(1);
        for (int i = 0; i < 24; i++) begin
            lfsr = next_rand(lfsr);
            op = lfsr[9:0];
            if (op == skip_pkg::OP_STANDBY || op == skip_pkg::OP_SERIAL
                || op == skip_pkg::OP_TIMER_ONE) begin
                op = op ^ 10'h100;
            end
            @(posedge clk_i);
            standby_return_i <= lfsr[12];
            run_op(op, sk);
            check(32'(sk), 32'h00000000, "random word");
        end
        check(32'(flag_o), 32'h00000003, "flags kept");
        // sticky status, mask gating, clear by writing ones
        wb(1'b0, skip_pkg::ADR_STATUS, 32'h00000000, q);
        check(q, 32'h00000007, "status events");
        wb(1'b1, skip_pkg::ADR_MASK, 32'h00000004, q);
        repeat (2) @(posedge clk_i);
        #1;
        check(32'(irq_o), 32'h00000001, "irq raised");
        wb(1'b1, skip_pkg::ADR_MASK, 32'h00000000, q);
        repeat (2) @(posedge clk_i);
        #1;
        check(32'(irq_o), 32'h00000000, "irq masked");
        wb(1'b1, skip_pkg::ADR_MASK, 32'h00000007, q);
        wb(1'b0, skip_pkg::ADR_MASK, 32'h00000000, q);
        check(q, 32'h00000007, "mask readback");
        wb(1'b1, skip_pkg::ADR_STATUS, 32'h00000007, q);
        repeat (2) @(posedge clk_i);
        #1;
        check(32'(irq_o), 32'h00000000, "irq cleared");
        wb(1'b0, skip_pkg::ADR_STATUS, 32'h00000000, q);
        check(q, 32'h00000000, "status cleared");
        // enable low freezes flags, skip and status
        @(posedge clk_i);
        ce <= 1'b0;
        pulse(0);
        run_op(skip_pkg::OP_SERIAL, sk);
        check(32'(sk), 32'h00000000, "frozen skip");
        check(32'(flag_o), 32'h00000003, "frozen flags");
        @(posedge clk_i);
        ce <= 1'b1;
        wb(1'b0, skip_pkg::ADR_STATUS, 32'h00000000, q);
        check(q, 32'h00000000, "frozen status");
        complete_run;
    end
endmodule
